// >>> core/slp_pkg.sv
// Constants and types shared by the sleep mode controller
package slp_pkg;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  CTRL_OFS     = 8'h00;
	localparam logic [7:0]  GATE_OFS     = 8'h04;
	localparam logic [7:0]  CFG_OFS      = 8'h08;
	localparam logic [7:0]  STAT_OFS     = 8'h0c;
	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int          CTRL_ARM_BIT  = 5;
	localparam int          CTRL_MODE_LSB = 3;
	localparam int          CFG_CONV_EN   = 0;
	localparam int          CFG_CMP_DIS   = 1;
	localparam int          CFG_CMP_REF   = 2;
	localparam int          CFG_LVL0      = 3;
	localparam int          CFG_LVL1      = 4;
	localparam int          CFG_XTAL      = 5;
	localparam int          CFG_W         = 6;
	localparam int          NUM_PERIPH    = 4;
	localparam logic [5:0]  CTRL_RST      = 6'h00;
	localparam logic [3:0]  GATE_RST      = 4'h0;
	localparam logic [5:0]  CFG_RST       = 6'h00;
	// ****************************************
	// Sleep mode codes
	// ****************************************
	localparam logic [1:0]  MODE_IDLE     = 2'b00;
	localparam logic [1:0]  MODE_NOISE    = 2'b01;
	localparam logic [1:0]  MODE_PDOWN    = 2'b10;
	localparam logic [1:0]  MODE_STBY     = 2'b11;
	localparam logic [2:0]  BOD_OFF_CODE  = 3'b111;
	// ****************************************
	// Timing counts in pclk cycles
	// ****************************************
	localparam int          STBY_WAKE_CYC = 6;
	localparam int          HALT_CYC      = 4;
	localparam int          STARTUP_CYC   = 16;
	localparam int          DLY_W         = 8;
	// ****************************************
	// Controller states
	// ****************************************
	typedef enum logic [1:0] {
		ST_ACTIVE,
		ST_SLEEP,
		ST_START,
		ST_HALT
	} slp_state_t;
endpackage

// >>> core/slp_delay.sv
// Down counter that times start-up and halt intervals
`timescale 1ns/1ps
`default_nettype none
module slp_delay #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Control
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	// Status
	output logic              last
);
	logic [W-1:0] cnt_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else if (load) begin
			cnt_reg <= load_val;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - W'(1);
		end
	end

	// High in the final counted cycle
	assign last = (cnt_reg == W'(1));
endmodule
`default_nettype wire

// >>> core/slp_ctrl.sv
// Sleep mode and clock gating controller with APB registers
// Behaviour
// RULE_01: Sleep only when sleep_arm is set and the core executes sleep.
// RULE_02: Idle stops core and flash clocks; others and oscillator keep running.
// RULE_03: Noise mode stops io, core, flash clocks; converter clock and oscillator run.
// RULE_04: Noise mode wakes on conversion done, resets, program ready, level0, pin change.
// RULE_05: Power-down stops oscillator and all generated clocks.
// RULE_06: Power-down wakes only on resets, level on line 0, pin change; the code also wakes on a level on line 1.
// RULE_07: In deeper modes lines 0 and 1 wake only when level sensing.
// RULE_08: Mode 11 with crystal option is standby: power-down with oscillator running.
// RULE_09: Wake from standby takes six clock cycles.
// RULE_10: Interrupt wake keeps core halted four extra cycles, then handler runs.
// RULE_11: Register file and SRAM are never disturbed by sleep or wake.
// RULE_12: Reset during sleep wakes device and starts from reset vector.
// RULE_13: Entering idle or noise mode with converter enabled starts a conversion.
// RULE_14: In idle any enabled interrupt wakes the device.
// RULE_15: Gate bit stops peripheral clock and blocks its register access.
// RULE_16: Clearing gate bit restarts the clock with state kept.
// RULE_17: Peripheral gating matters in active and idle; deeper modes stop clocks anyway.
// RULE_18: Enabled converter stays enabled in sleep; re-enable marks extended conversion.
// RULE_19: Power-down and standby disable comparator; its reference stays unless disabled.
// RULE_20: Brown-out detector enabled by fuse stays enabled in all modes.
// RULE_21: External level wake source holds its level long enough to be seen.
// RULE_22: Mode sampled at sleep; oscillator restarts and start-up delay precedes core clock.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module slp_ctrl
	import slp_pkg::*;
#(
	parameter int STARTUP = STARTUP_CYC
) (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Core handshake
	input  wire logic                  sleep_exec,
	output logic                       wake_irq,
	output logic                       reset_vector,
	// Internal interrupt requests
	input  wire logic                  conv_done_irq,
	input  wire logic                  self_program_op_ready_irq,
	input  wire logic                  watchdog_unit_irq,
	input  wire logic                  universal_serial_unit_irq,
	input  wire logic                  other_io_irq,
	// Asynchronous wake and reset sources
	input  wire logic                  ext_irq_line0,
	input  wire logic                  ext_irq_line1,
	input  wire logic                  pin_change_irq,
	input  wire logic                  ext_reset_req,
	input  wire logic                  watchdog_unit_reset_req,
	input  wire logic                  bod_reset_req,
	input  wire logic [2:0]            brownout_level_fuse,
	// Clock domain enables
	output logic                       core_clock_en,
	output logic                       flash_clock_en,
	output logic                       io_clock_en,
	output logic                       converter_clock_en,
	output logic                       fast_peripheral_clock_en,
	output logic                       osc_en,
	output logic      [NUM_PERIPH-1:0] periph_clock_en,
	output logic      [NUM_PERIPH-1:0] periph_access_en,
	// Analog module control
	output logic                       conv_enable,
	output logic                       conv_start,
	output logic                       conv_extended,
	output logic                       comparator_en,
	output logic                       reference_en,
	output logic                       brownout_en
);
	if (STARTUP < 1 || STARTUP > (2**DLY_W) - 1) begin : g_chk
		$error("STARTUP out of range");
	end
	localparam int SYN_W = 9;
	slp_state_t              state_reg;
	logic [5:0]              ctrl_reg;
	logic [NUM_PERIPH-1:0]   gate_reg;
	logic [CFG_W-1:0]        cfg_reg;
	logic [1:0]              mode_reg;
	logic                    conv_en_prev_reg;
	logic [SYN_W-1:0]        syn1_reg;
	logic [SYN_W-1:0]        syn2_reg;
	logic                    wr_en;
	logic                    dly_load;
	logic [DLY_W-1:0]        dly_val;
	logic                    dly_last;
	logic                    enter_sleep;
	logic [1:0]              sel_mode;
	logic                    lvl0;
	logic                    lvl1;
	logic                    pc_s;
	logic                    rst_wake;
	logic                    irq_wake;
	logic                    deep_now;
	logic                    core_next;
	logic                    flash_next;
	logic                    io_next;
	logic                    conv_next;
	logic                    pck_next;
	logic                    osc_next;
	// ****************************************
	// Input synchronisers
	// ****************************************
	// Level wake sources are held by the far side until seen here RULE_21
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			syn1_reg <= '0;
			syn2_reg <= '0;
		end else begin
			syn1_reg <= {brownout_level_fuse, bod_reset_req, watchdog_unit_reset_req,
				ext_reset_req, pin_change_irq, ext_irq_line1, ext_irq_line0};
			syn2_reg <= syn1_reg;
		end
	end
	// ****************************************
	// APB register access
	// ****************************************
	assign wr_en = psel && penable && pready && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			if (psel && !penable) begin
				unique case (paddr)
					CTRL_OFS: prdata <= {26'h0, ctrl_reg};
					GATE_OFS: prdata <= {28'h0, gate_reg};
					CFG_OFS:  prdata <= {26'h0, cfg_reg};
					STAT_OFS: prdata <= {27'h0, conv_extended, mode_reg, state_reg};
					default:  pslverr <= 1'b1;
				endcase
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RST;
			gate_reg <= GATE_RST;
			cfg_reg  <= CFG_RST;
		end else if (wr_en) begin
			unique case (paddr)
				CTRL_OFS: ctrl_reg <= pwdata[5:0] & 6'h38;
				GATE_OFS: gate_reg <= pwdata[NUM_PERIPH-1:0]; // RULE_15 RULE_16
				CFG_OFS:  cfg_reg  <= pwdata[CFG_W-1:0];
				default:  ;
			endcase
		end
	end
	// ****************************************
	// Wake qualification
	// ****************************************
	// Mode 11 without crystal option falls back to power-down RULE_08
	assign sel_mode = (ctrl_reg[CTRL_MODE_LSB +: 2] == MODE_STBY && !cfg_reg[CFG_XTAL])
		? MODE_PDOWN : ctrl_reg[CTRL_MODE_LSB +: 2];
	assign enter_sleep = (state_reg == ST_ACTIVE) && sleep_exec
		&& ctrl_reg[CTRL_ARM_BIT]; // RULE_01
	assign lvl0 = syn2_reg[0] && cfg_reg[CFG_LVL0]; // RULE_07
	assign lvl1 = syn2_reg[1] && cfg_reg[CFG_LVL1]; // RULE_07
	assign pc_s = syn2_reg[2];
	assign rst_wake = |syn2_reg[5:3];
	assign deep_now = (mode_reg == MODE_PDOWN) || (mode_reg == MODE_STBY);
	always_comb begin
		unique case (mode_reg)
			MODE_IDLE:  irq_wake = syn2_reg[0] || syn2_reg[1] || pc_s || conv_done_irq
				|| self_program_op_ready_irq || watchdog_unit_irq || universal_serial_unit_irq
				|| other_io_irq; // RULE_14
			MODE_NOISE: irq_wake = conv_done_irq || self_program_op_ready_irq
				|| lvl0 || lvl1 || pc_s; // RULE_04
			default:    irq_wake = lvl0 || lvl1 || pc_s; // RULE_06
		endcase
	end
	// ****************************************
	// Sleep state machine
	// ****************************************
	always_comb begin
		dly_load = 1'b0;
		dly_val  = DLY_W'(HALT_CYC);
		if (state_reg == ST_SLEEP && !rst_wake && irq_wake) begin
			dly_load = 1'b1;
			if (mode_reg == MODE_STBY) begin
				dly_val = DLY_W'(STBY_WAKE_CYC); // RULE_09
			end else if (mode_reg == MODE_PDOWN) begin
				dly_val = DLY_W'(STARTUP); // RULE_22
			end
		end else if (state_reg == ST_START && !rst_wake && dly_last) begin
			dly_load = 1'b1; // RULE_10
		end
	end
	slp_delay #(
		.W        (DLY_W)
	) u_delay (
		.pclk     (pclk),
		.presetn  (presetn),
		.load     (dly_load),
		.load_val (dly_val),
		.last     (dly_last)
	);
	// Wake never resets core state, so register file and SRAM survive RULE_11
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg    <= ST_ACTIVE;
			mode_reg     <= MODE_IDLE;
			wake_irq     <= 1'b0;
			reset_vector <= 1'b0;
		end else begin
			wake_irq     <= 1'b0;
			reset_vector <= 1'b0;
			unique case (state_reg)
				ST_ACTIVE: if (enter_sleep) begin
					state_reg <= ST_SLEEP;
					mode_reg  <= sel_mode; // RULE_22
				end
				ST_SLEEP: if (rst_wake) begin
					state_reg    <= ST_ACTIVE;
					reset_vector <= 1'b1; // RULE_12
				end else if (irq_wake) begin
					state_reg <= (mode_reg == MODE_IDLE || mode_reg == MODE_NOISE)
						? ST_HALT : ST_START;
				end
				ST_START: if (rst_wake) begin
					state_reg    <= ST_ACTIVE;
					reset_vector <= 1'b1; // RULE_12
				end else if (dly_last) begin
					state_reg <= ST_HALT;
				end
				ST_HALT: if (dly_last) begin
					state_reg <= ST_ACTIVE;
					wake_irq  <= 1'b1; // RULE_10
				end
			endcase
		end
	end
	// ****************************************
	// Clock domain enables
	// ****************************************
	always_comb begin
		core_next  = 1'b1;
		flash_next = 1'b1;
		io_next    = 1'b1;
		conv_next  = 1'b1;
		pck_next   = 1'b1;
		osc_next   = 1'b1;
		if (state_reg != ST_ACTIVE) begin
			core_next  = 1'b0; // RULE_02
			flash_next = 1'b0;
		end
		if (state_reg == ST_SLEEP || state_reg == ST_START) begin
			unique case (mode_reg)
				MODE_IDLE:  ;
				MODE_NOISE: begin
					io_next  = 1'b0; // RULE_03
					pck_next = 1'b0;
				end
				MODE_PDOWN: begin
					io_next   = 1'b0; // RULE_05
					conv_next = 1'b0;
					pck_next  = 1'b0;
					osc_next  = (state_reg == ST_START); // RULE_22
				end
				MODE_STBY: begin
					io_next   = 1'b0; // RULE_08
					conv_next = 1'b0;
					pck_next  = 1'b0;
				end
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_clock_en            <= 1'b1;
			flash_clock_en           <= 1'b1;
			io_clock_en              <= 1'b1;
			converter_clock_en       <= 1'b1;
			fast_peripheral_clock_en <= 1'b1;
			osc_en                   <= 1'b1;
			periph_clock_en          <= '1;
			periph_access_en         <= '1;
		end else begin
			core_clock_en            <= core_next;
			flash_clock_en           <= flash_next;
			io_clock_en              <= io_next;
			converter_clock_en       <= conv_next;
			fast_peripheral_clock_en <= pck_next;
			osc_en                   <= osc_next;
			periph_clock_en          <= {NUM_PERIPH{io_next}} & ~gate_reg; // RULE_15 RULE_17
			periph_access_en         <= ~gate_reg; // RULE_15
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_enable      <= 1'b0;
			conv_en_prev_reg <= 1'b0;
			conv_start       <= 1'b0;
			conv_extended    <= 1'b1;
			comparator_en    <= 1'b0;
			reference_en     <= 1'b0;
			brownout_en      <= 1'b0;
		end else begin
			conv_enable      <= cfg_reg[CFG_CONV_EN]; // RULE_18
			conv_en_prev_reg <= cfg_reg[CFG_CONV_EN];
			conv_start       <= enter_sleep && cfg_reg[CFG_CONV_EN]
				&& (sel_mode == MODE_IDLE || sel_mode == MODE_NOISE); // RULE_13
			// Re-enable after an off period sets; set wins over clear
			if (cfg_reg[CFG_CONV_EN] && !conv_en_prev_reg) begin
				conv_extended <= 1'b1; // RULE_18
			end else if (conv_start || conv_done_irq) begin
				conv_extended <= 1'b0;
			end
			comparator_en <= !cfg_reg[CFG_CMP_DIS]
				&& !(state_reg != ST_ACTIVE && state_reg != ST_HALT && deep_now); // RULE_19
			reference_en  <= cfg_reg[CFG_CMP_REF] && !cfg_reg[CFG_CMP_DIS]; // RULE_19
			brownout_en   <= (syn2_reg[8:6] != BOD_OFF_CODE); // RULE_20
		end
	end
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_halt4;
		(state_reg == ST_HALT)[*4] ##1 (state_reg == ST_ACTIVE && wake_irq);
	endsequence
	arm_needed_a: assert property ((state_reg == ST_ACTIVE && sleep_exec
		&& !ctrl_reg[CTRL_ARM_BIT]) |=> state_reg == ST_ACTIVE) // RULE_01
		else $error("sleep entered without arm");
	idle_clocks_a: assert property ((state_reg == ST_SLEEP && mode_reg == MODE_IDLE)
		|=> !core_clock_en && !flash_clock_en && io_clock_en && osc_en) // RULE_02
		else $error("idle clock enables wrong");
	noise_clocks_a: assert property ((state_reg == ST_SLEEP && mode_reg == MODE_NOISE)
		|=> !io_clock_en && converter_clock_en && osc_en) // RULE_03
		else $error("noise mode clock enables wrong");
	pdown_osc_a: assert property ((state_reg == ST_SLEEP && mode_reg == MODE_PDOWN)
		|=> !osc_en && !converter_clock_en) // RULE_05
		else $error("power-down left oscillator on");
	stby_six_a: assert property ((state_reg == ST_SLEEP && mode_reg == MODE_STBY
		&& irq_wake && !rst_wake) |=> (state_reg == ST_START)[*6]) // RULE_09
		else $error("standby wake not six cycles");
	halt_four_a: assert property ($rose(state_reg == ST_HALT) |-> s_halt4) // RULE_10
		else $error("wake halt not four cycles");
	reset_wake_a: assert property ((state_reg == ST_SLEEP && rst_wake)
		|=> reset_vector && state_reg == ST_ACTIVE) // RULE_12
		else $error("reset did not wake to vector");
	conv_auto_a: assert property ((enter_sleep && cfg_reg[CFG_CONV_EN]
		&& sel_mode == MODE_IDLE) |=> conv_start ##1 !conv_start) // RULE_13
		else $error("no conversion on idle entry");
	gate_clock_a: assert property (gate_reg[0] |=> !periph_clock_en[0]
		&& !periph_access_en[0]) // RULE_15
		else $error("gated peripheral still clocked");
	deep_edge_a: assert property ((state_reg == ST_SLEEP && deep_now && !cfg_reg[CFG_LVL0]
		&& !cfg_reg[CFG_LVL1] && !pc_s && !rst_wake) |=> state_reg == ST_SLEEP) // RULE_07
		else $error("edge line woke deep sleep");
	comp_off_a: assert property ((state_reg == ST_SLEEP && deep_now)
		|=> !comparator_en) // RULE_19
		else $error("comparator on in deep sleep");
endmodule
`default_nettype wire

// >>> verification/slp_core_model.sv
// Behavioural model of the core and the wake sources facing the sleep controller
`timescale 1ns/1ps
`default_nettype none
module slp_core_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Bench commands
	input  wire logic        go_sleep,
	input  wire logic [10:0] src_req,
	// Controller answers
	input  wire logic        wake_irq,
	input  wire logic        reset_vector,
	// Core and wake sources
	output logic             sleep_exec,
	output logic [10:0]      src_out
);
	// ****************************************
	// Sleep instruction
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_exec <= 1'b0;
		end else begin
			sleep_exec <= go_sleep;
		end
	end
	// ****************************************
	// Requests held until the wake is reported
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_out <= 11'h000;
		end else if (wake_irq || reset_vector) begin
			src_out <= 11'h000;
		end else begin
			src_out <= src_out | src_req;
		end
	end
endmodule
`default_nettype wire

// >>> verification/tb_sleep_mode_controller.sv
// Self-checking bench for the sleep mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_sleep_mode_controller;
	import slp_pkg::*;
	localparam int STARTUP_T = 2;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        go_sleep = 1'b0;
	logic [10:0] src_req = 11'h000;
	logic [2:0]  fuse = 3'b000;
	logic [10:0] src;
	logic        sleep_exec;
	logic [31:0] prdata;
	logic        pready, pslverr, wake_irq, reset_vector;
	logic        core_clock_en, flash_clock_en, io_clock_en, converter_clock_en;
	logic        fast_peripheral_clock_en, osc_en, conv_enable, conv_start, conv_extended;
	logic        comparator_en, reference_en, brownout_en;
	logic [3:0]  periph_clock_en, periph_access_en;
	int          errors = 0, n_checks = 0, n_wake = 0, n_rstv = 0, n_cst = 0, pd_n = 0;
	// ****************************************
	// Design, partner, clock, monitors
	// ****************************************
	slp_ctrl #(.STARTUP(STARTUP_T)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleep_exec(sleep_exec), .wake_irq(wake_irq), .reset_vector(reset_vector),
		.conv_done_irq(src[0]), .self_program_op_ready_irq(src[1]),
		.watchdog_unit_irq(src[2]), .universal_serial_unit_irq(src[3]),
		.other_io_irq(src[4]), .ext_irq_line0(src[5]), .ext_irq_line1(src[6]),
		.pin_change_irq(src[7]), .ext_reset_req(src[8]), .watchdog_unit_reset_req(src[9]),
		.bod_reset_req(src[10]), .brownout_level_fuse(fuse),
		.core_clock_en(core_clock_en), .flash_clock_en(flash_clock_en),
		.io_clock_en(io_clock_en), .converter_clock_en(converter_clock_en),
		.fast_peripheral_clock_en(fast_peripheral_clock_en), .osc_en(osc_en),
		.periph_clock_en(periph_clock_en), .periph_access_en(periph_access_en),
		.conv_enable(conv_enable), .conv_start(conv_start), .conv_extended(conv_extended),
		.comparator_en(comparator_en), .reference_en(reference_en), .brownout_en(brownout_en)
	);
	slp_core_model core_u (
		.pclk(pclk), .presetn(presetn), .go_sleep(go_sleep), .src_req(src_req),
		.wake_irq(wake_irq), .reset_vector(reset_vector), .sleep_exec(sleep_exec),
		.src_out(src)
	);
	always #4 pclk = ~pclk;
	always @(posedge pclk) begin
		n_wake <= n_wake + (wake_irq === 1'b1);
		n_rstv <= n_rstv + (reset_vector === 1'b1);
		n_cst <= n_cst + (conv_start === 1'b1);
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	function automatic logic [31:0] clks();
		return {26'h0, core_clock_en, flash_clock_en, io_clock_en, converter_clock_en,
			fast_peripheral_clock_en, osc_en};
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("ERROR %0t mismatch seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic exec_sleep();
		@(posedge pclk);
		go_sleep <= 1'b1;
		@(posedge pclk);
		go_sleep <= 1'b0;
		cyc(5);
	endtask
	task automatic slp(input logic [1:0] m, input logic [5:0] c);
		wr(CFG_OFS, {26'h0, c});
		wr(CTRL_OFS, {26'h0, 1'b1, m, 3'h0});
		exec_sleep();
	endtask
	task automatic wake(input logic [10:0] s, output int n);
		n = 0;
		@(posedge pclk);
		src_req <= s;
		@(posedge pclk);
		src_req <= 11'h000;
		while (wake_irq !== 1'b1 && reset_vector !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		cyc(3);
	endtask
	task automatic nowake(input logic [10:0] s);
		int w;
		w = n_wake + n_rstv;
		@(posedge pclk);
		src_req <= s;
		@(posedge pclk);
		src_req <= 11'h000;
		cyc(20);
		chk(n_wake + n_rstv, w);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		chk(clks(), 32'h3f);
		chk({22'h0, periph_clock_en, periph_access_en, conv_extended, comparator_en}, 32'h3ff);
		apb(1'b0, CTRL_OFS, 32'h0, r, e);
		chk(r, {26'h0, CTRL_RST});
		apb(1'b0, 8'h10, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1);
		wr(CTRL_OFS, {26'h0, 1'b0, MODE_PDOWN, 3'h0});
		exec_sleep();
		chk(clks(), 32'h3f);
	endtask
	task automatic t_idle();
		int n, c, i;
		c = n_cst;
		slp(MODE_IDLE, 6'h01);
		chk(clks(), 32'h0f);
		chk(n_cst - c, 1);
		chk({conv_enable, conv_extended}, 2'b10);
		wr(GATE_OFS, 32'h5);
		cyc(2);
		chk({periph_clock_en, periph_access_en}, 8'haa);
		wr(CTRL_OFS, {26'h0, 1'b1, MODE_PDOWN, 3'h0});
		cyc(3);
		chk(clks(), 32'h0f);
		for (i = 2; i < 5; i++) begin
			if (i > 2) slp(MODE_IDLE, 6'h01);
			wake(11'h001 << i, n);
			chk(n < 300, 1);
			chk(core_clock_en, 1'b1);
		end
		chk({periph_clock_en, periph_access_en}, 8'haa);
		wr(GATE_OFS, 32'h0);
		cyc(2);
		chk({periph_clock_en, periph_access_en}, 8'hff);
	endtask
	task automatic t_noise();
		int n, i;
		int b[4] = '{0, 1, 5, 7};
		for (i = 0; i < 4; i++) begin
			slp(MODE_NOISE, 6'h09);
			chk(clks(), 32'h05);
			if (i == 0) nowake(11'h010);
			wake(11'h001 << b[i], n);
			chk(n < 300, 1);
		end
	endtask
	task automatic t_pdown();
		int n;
		slp(MODE_PDOWN, 6'h0c);
		chk(clks(), 32'h00);
		chk({comparator_en, reference_en, brownout_en}, 3'b011);
		nowake(11'h04c);
		wake(11'h020, pd_n);
		chk(pd_n < 300, 1);
		slp(MODE_PDOWN, 6'h08);
		wake(11'h080, n);
		chk(n < 300, 1);
	endtask
	task automatic t_stby();
		int n;
		logic [31:0] r;
		logic        e;
		slp(MODE_STBY, 6'h28);
		chk(clks(), 32'h01);
		chk(comparator_en, 1'b0);
		wake(11'h020, n);
		chk(n - pd_n, STBY_WAKE_CYC - STARTUP_T);
		apb(1'b0, CFG_OFS, 32'h0, r, e);
		chk(r, 32'h28);
		fuse <= 3'b111;
		cyc(4);
		chk(brownout_en, 1'b0);
		wr(CFG_OFS, 32'h01);
		cyc(2);
		chk(conv_extended, 1'b1);
	endtask
	task automatic t_resets();
		int n, c, i;
		for (i = 0; i < 3; i++) begin
			c = n_rstv;
			slp(MODE_PDOWN, 6'h08);
			wake(11'h100 << i, n);
			chk(n_rstv - c, 1);
			chk(core_clock_en, 1'b1);
		end
	endtask
	// ****************************************
	// Main sequence, watchdog, verdict
	// ****************************************
	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		cyc(4);
		t_reset();
		t_idle();
		t_noise();
		t_pdown();
		t_stby();
		t_resets();
		final_report();
	end
	initial begin
		#200000;
		errors++;
		final_report();
	end
endmodule
`default_nettype wire
